//--- src/rcp_pkg.sv
// Package with register map, field positions, reset values and timing.
package rcp_pkg;
    // Special function register addresses.
    localparam logic [7:0] ADDR_X_LOW = 8'h9A;
    localparam logic [7:0] ADDR_X_HIGH = 8'h9B;
    localparam logic [7:0] ADDR_Y_LOW = 8'h9C;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h9D;
    localparam logic [7:0] ADDR_Z_LOW = 8'h9E;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h9F;
    localparam logic [7:0] ADDR_STATUS = 8'hA0;
    localparam logic [7:0] ADDR_CONTROL = 8'hA1;
    // Reset values.
    localparam logic [7:0] RESET_CONTROL = 8'h62;
    localparam logic [7:0] RESET_STATUS = 8'h00;
    localparam logic [7:0] RESET_POWER = 8'h00;
    // Control register fields.
    localparam int CON_START = 0;
    localparam int CON_FUNC_LO = 1;
    localparam int CON_ROTATE = 3;
    localparam int CON_START_METHOD = 4;
    localparam int CON_X_UNSIGNED = 5;
    localparam int CON_PRESCALE_LO = 6;
    // Status register fields.
    localparam int STA_BUSY = 0;
    localparam int STA_ERROR = 1;
    localparam int STA_END = 2;
    localparam int STA_INT_ENABLE = 3;
    localparam int STA_READ_MAP = 4;
    localparam int STA_KEEP_X = 5;
    localparam int STA_KEEP_Y = 6;
    localparam int STA_KEEP_Z = 7;
    // Power control field.
    localparam int PWR_DISABLE = 6;
    localparam logic [7:0] PWR_WRITE_MASK = 8'h7F;
    // Function select codes.
    localparam logic [1:0] FUNC_LINEAR = 2'h0;
    localparam logic [1:0] FUNC_CIRCULAR = 2'h1;
    localparam logic [1:0] FUNC_RESERVED = 2'h2;
    localparam logic [1:0] FUNC_HYPERBOLIC = 2'h3;
    localparam logic [1:0] PRESCALE_RESERVED = 2'h3;
    // Timing: a calculation runs this many clock cycles; the end flag follows a cycle later.
    localparam int CALC_CYCLES = 41;
    localparam int Z_WIDTH = 20;
    localparam int Z_DROP = 4;

    // One special function register access.
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcp_access_type;

    // Result of the iteration engine at the end of a calculation.
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [19:0] z;
        logic overflow;
    } rcp_result_type;
endpackage : rcp_pkg

//--- src/rcp_shadow_word.sv
`timescale 1ns/100ps
// One 16-bit shadow register written a byte at a time.
module rcp_shadow_word (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // Byte writes.
    input wire logic i_write_low,
    input wire logic i_write_high,
    input wire logic [7:0] i_wdata,
    // Stored value.
    output logic [15:0] o_value
);
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_value <= 16'h0000;
        end else begin
            if (i_write_low) begin
                o_value[7:0] <= i_wdata;
            end
            if (i_write_high) begin
                o_value[15:8] <= i_wdata;
            end
        end
    end
endmodule : rcp_shadow_word

//--- src/rcp_calc_timer.sv
`timescale 1ns/100ps
// Counts the cycles of one calculation and flags its end.
module rcp_calc_timer #(
    parameter int CYCLES = rcp_pkg::CALC_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // Start of a calculation.
    input wire logic i_start,
    // Running level and one-cycle end pulse.
    output logic o_running,
    output logic o_done
);
    localparam logic [7:0] LAST = 8'(CYCLES - 1);
    logic [7:0] count;
    wire at_last = o_running && (count == LAST);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= 8'h00;
            o_running <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= at_last;
            if (i_start && !o_running) begin
                o_running <= 1'b1;
                count <= 8'h00;
            end else if (at_last) begin
                o_running <= 1'b0;
            end else if (o_running) begin
                count <= count + 8'h01;
            end
        end
    end
endmodule : rcp_calc_timer

//--- src/rcp_top.sv
`timescale 1ns/100ps
// Register interface of the rotation coprocessor.
// How it works
// - Control writes ignored while busy.
// - Explicit start trigger, cleared when calculation begins.
// - Trigger and control bits share one write.
// - Bits 2:1 select linear, circular, hyperbolic.
// - Bit 3 selects vectoring or rotation.
// - Bit 4 selects auto or explicit start.
// - Bit 5 stored only; X reads the same either way.
// - Prescaler divides X, Y; code 11 kept.
// - Busy rises two cycles after trigger.
// - Error set on overflow, cleared by read/start.
// - End flag set at finish, cleared by software/Z low result read.
// - Status bit 3 enables interrupt request.
// - Status bit 4 selects result or shadow reads.
// - Keep bits block shadow load at start.
// - Shadow registers keep last written value.
// - Byte writes update one shadow byte anytime.
// - Status register allows single-bit read-modify-write.
// - Power bit 6 requests disable; bit 7 zero.
// - Calculation runs 41 cycles; end flag one cycle later.
// - Z kernel 20 bits; bus drops four LSBs.
module rcp_top #(
    parameter int CALC_CYCLES = rcp_pkg::CALC_CYCLES
) (
    // Clock and reset.
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Special function register bus.
    input wire logic I_SFR_WRITE,
    input wire logic I_SFR_READ,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic [7:0] I_SFR_WDATA,
    output logic [7:0] O_SFR_RDATA,
    // Power control register access, decoded by the system.
    input wire logic I_POWER_WRITE,
    input wire logic [7:0] I_POWER_WDATA,
    output logic [7:0] O_POWER_RDATA,
    // Iteration engine results.
    input wire rcp_pkg::rcp_result_type I_RESULT,
    // Engine set-up and status outputs.
    output logic O_START,
    output logic [1:0] O_FUNCTION,
    output logic O_ROTATE,
    output logic [1:0] O_PRESCALE,
    output logic [15:0] O_INIT_X,
    output logic [15:0] O_INIT_Y,
    output logic [15:0] O_INIT_Z,
    output logic [2:0] O_LOAD_MASK,
    output logic O_DISABLE_REQUEST,
    output logic O_IRQ
);
    rcp_pkg::rcp_access_type acc;
    logic [7:0] control;
    logic [7:0] status;
    logic [7:0] power;
    logic [15:0] shadow_x;
    logic [15:0] shadow_y;
    logic [15:0] shadow_z;
    logic [15:0] kernel_x;
    logic [15:0] kernel_y;
    logic [19:0] kernel_z;
    logic start_pending;
    logic running;
    logic done;
    logic done_q;
    logic overflow_q;
    logic end_prev;

    assign acc = '{write: I_SFR_WRITE, read: I_SFR_READ,
                   addr: I_SFR_ADDR, wdata: I_SFR_WDATA};

    // Address decode.
    wire wr_xl = acc.write && acc.addr == rcp_pkg::ADDR_X_LOW;
    wire wr_xh = acc.write && acc.addr == rcp_pkg::ADDR_X_HIGH;
    wire wr_yl = acc.write && acc.addr == rcp_pkg::ADDR_Y_LOW;
    wire wr_yh = acc.write && acc.addr == rcp_pkg::ADDR_Y_HIGH;
    wire wr_zl = acc.write && acc.addr == rcp_pkg::ADDR_Z_LOW;
    wire wr_zh = acc.write && acc.addr == rcp_pkg::ADDR_Z_HIGH;
    wire wr_status = acc.write && acc.addr == rcp_pkg::ADDR_STATUS;
    wire wr_control = acc.write && acc.addr == rcp_pkg::ADDR_CONTROL;
    wire rd_status = acc.read && acc.addr == rcp_pkg::ADDR_STATUS;
    wire rd_zl = acc.read && acc.addr == rcp_pkg::ADDR_Z_LOW;

    wire busy = status[rcp_pkg::STA_BUSY];
    wire read_map = status[rcp_pkg::STA_READ_MAP];
    wire explicit_mode = control[rcp_pkg::CON_START_METHOD];

    // A control write lands only while idle.
    wire control_take = wr_control && !busy;

    // Prescaler code 11 keeps the previous setting.
    wire [1:0] wr_prescale = acc.wdata[rcp_pkg::CON_PRESCALE_LO +: 2];
    wire [1:0] next_prescale = (wr_prescale == rcp_pkg::PRESCALE_RESERVED)
        ? control[rcp_pkg::CON_PRESCALE_LO +: 2] : wr_prescale;

    // Auto start on X low write, or explicit trigger set in one write.
    wire auto_start = wr_xl && !explicit_mode && !busy;
    wire trig_start = control[rcp_pkg::CON_START] && explicit_mode
        && !busy && !start_pending;
    wire begin_calc = auto_start || trig_start;

    // Control register.
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            control <= rcp_pkg::RESET_CONTROL;
        end else if (control_take) begin
            control <= {next_prescale, acc.wdata[5:0]};
        end else if (start_pending) begin
            control[rcp_pkg::CON_START] <= 1'b0;
        end
    end

    // Start request to busy, one cycle later.
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            start_pending <= 1'b0;
        end else begin
            start_pending <= begin_calc;
        end
    end

    rcp_calc_timer #(
        .CYCLES(CALC_CYCLES)
    ) u_timer (
        .i_clk(I_CLOCK),
        .i_nrst(I_NRST),
        .i_start(start_pending),
        .o_running(running),
        .o_done(done)
    );

    // Status register; hardware sets win over software clears.
    wire [7:0] sw_status = {acc.wdata[7:3], acc.wdata[rcp_pkg::STA_END],
                            2'b00};
    wire next_end = done || (status[rcp_pkg::STA_END]
        && !(rd_zl && !read_map)
        && !(wr_status && !acc.wdata[rcp_pkg::STA_END]));
    wire next_error = done_q ? overflow_q
        : (status[rcp_pkg::STA_ERROR] && !rd_status
           && !start_pending);

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            status <= rcp_pkg::RESET_STATUS;
            done_q <= 1'b0;
            overflow_q <= 1'b0;
        end else begin
            done_q <= done;
            overflow_q <= I_RESULT.overflow;
            if (wr_status) begin
                status[7:3] <= sw_status[7:3];
            end
            status[rcp_pkg::STA_BUSY] <= start_pending || running
                && !done;
            status[rcp_pkg::STA_ERROR] <= next_error;
            status[rcp_pkg::STA_END] <= next_end;
        end
    end

    // Shadow registers keep the last software write.
    rcp_shadow_word u_shadow_x (
        .i_clk(I_CLOCK), .i_nrst(I_NRST), .i_write_low(wr_xl),
        .i_write_high(wr_xh), .i_wdata(acc.wdata), .o_value(shadow_x)
    );
    rcp_shadow_word u_shadow_y (
        .i_clk(I_CLOCK), .i_nrst(I_NRST), .i_write_low(wr_yl),
        .i_write_high(wr_yh), .i_wdata(acc.wdata), .o_value(shadow_y)
    );
    rcp_shadow_word u_shadow_z (
        .i_clk(I_CLOCK), .i_nrst(I_NRST), .i_write_low(wr_zl),
        .i_write_high(wr_zh), .i_wdata(acc.wdata), .o_value(shadow_z)
    );

    // Kernel registers: loaded at start unless kept, updated at the end.
    wire [2:0] load_mask = ~status[7:5];
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            kernel_x <= 16'h0000;
            kernel_y <= 16'h0000;
            kernel_z <= 20'h00000;
        end else if (done) begin
            kernel_x <= I_RESULT.x;
            kernel_y <= I_RESULT.y;
            kernel_z <= I_RESULT.z;
        end else if (start_pending) begin
            if (load_mask[0]) begin
                kernel_x <= shadow_x;
            end
            if (load_mask[1]) begin
                kernel_y <= shadow_y;
            end
            if (load_mask[2]) begin
                kernel_z <= {shadow_z, 4'h0};
            end
        end
    end

    // No output carries the X format bit to the engine; the view passes kernel bits as is.
    wire circ_vec = control[2:1] == rcp_pkg::FUNC_CIRCULAR
        && !control[rcp_pkg::CON_ROTATE];
    wire x_unsigned = circ_vec && control[rcp_pkg::CON_X_UNSIGNED];
    wire [15:0] x_view = x_unsigned ? kernel_x
        : kernel_x;
    wire [15:0] z_view = kernel_z[rcp_pkg::Z_WIDTH-1:rcp_pkg::Z_DROP];

    // Read mux selected by the read map bit.
    wire [15:0] rx = read_map ? shadow_x : x_view;
    wire [15:0] ry = read_map ? shadow_y : kernel_y;
    wire [15:0] rz = read_map ? shadow_z : z_view;
    logic [7:0] rmux;
    always_comb begin
        case (acc.addr)
            rcp_pkg::ADDR_X_LOW: rmux = rx[7:0];
            rcp_pkg::ADDR_X_HIGH: rmux = rx[15:8];
            rcp_pkg::ADDR_Y_LOW: rmux = ry[7:0];
            rcp_pkg::ADDR_Y_HIGH: rmux = ry[15:8];
            rcp_pkg::ADDR_Z_LOW: rmux = rz[7:0];
            rcp_pkg::ADDR_Z_HIGH: rmux = rz[15:8];
            rcp_pkg::ADDR_STATUS: rmux = status;
            rcp_pkg::ADDR_CONTROL: rmux = control;
            default: rmux = 8'h00;
        endcase
    end

    // Power control register; bit 7 stays zero.
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            power <= rcp_pkg::RESET_POWER;
        end else if (I_POWER_WRITE) begin
            power <= I_POWER_WDATA & rcp_pkg::PWR_WRITE_MASK;
        end
    end

    // Registered outputs.
    wire end_rise = status[rcp_pkg::STA_END] && !end_prev;
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_SFR_RDATA <= 8'h00;
            O_POWER_RDATA <= 8'h00;
            O_START <= 1'b0;
            O_FUNCTION <= rcp_pkg::FUNC_CIRCULAR;
            O_ROTATE <= 1'b0;
            O_PRESCALE <= 2'h1;
            O_INIT_X <= 16'h0000;
            O_INIT_Y <= 16'h0000;
            O_INIT_Z <= 16'h0000;
            O_LOAD_MASK <= 3'h7;
            O_DISABLE_REQUEST <= 1'b0;
            O_IRQ <= 1'b0;
            end_prev <= 1'b0;
        end else begin
            O_SFR_RDATA <= acc.read ? rmux : 8'h00;
            O_POWER_RDATA <= power;
            O_START <= start_pending;
            O_FUNCTION <= control[2:1];
            O_ROTATE <= control[rcp_pkg::CON_ROTATE];
            O_PRESCALE <= control[rcp_pkg::CON_PRESCALE_LO +: 2];
            O_INIT_X <= shadow_x;
            O_INIT_Y <= shadow_y;
            O_INIT_Z <= shadow_z;
            O_LOAD_MASK <= load_mask;
            O_DISABLE_REQUEST <= power[rcp_pkg::PWR_DISABLE];
            end_prev <= status[rcp_pkg::STA_END];
            O_IRQ <= end_rise
                && status[rcp_pkg::STA_INT_ENABLE];
        end
    end
endmodule : rcp_top

//--- testbench/rcp_engine_model.sv
`timescale 1ns/100ps
// Behavioural iteration engine that holds the kernel registers.
module rcp_engine_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // Set-up from the register interface.
    input wire logic i_start,
    input wire logic [15:0] i_init_x,
    input wire logic [15:0] i_init_y,
    input wire logic [15:0] i_init_z,
    input wire logic [2:0] i_load_mask,
    input wire logic i_overflow,
    // Kernel values as results.
    output rcp_pkg::rcp_result_type o_result
);
    // A cleared mask bit keeps the last X or Y result; Z always loads the new initial value.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_result <= '0;
        end else if (i_start) begin
            o_result.x <= i_load_mask[0] ? i_init_x : o_result.x;
            o_result.y <= i_load_mask[1] ? i_init_y : o_result.y;
            o_result.z <= {i_init_z, 4'h0};
            o_result.overflow <= i_overflow;
        end
    end
endmodule : rcp_engine_model

//--- testbench/rcp_top_assertions.sv
`timescale 1ns/100ps
// Concurrent checks on the rotator register interface ports.
module rcp_top_assertions #(
    parameter int CALC_CYCLES = rcp_pkg::CALC_CYCLES
) (
    // Clock and reset.
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Register bus.
    input wire logic I_SFR_WRITE,
    input wire logic I_SFR_READ,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic [7:0] O_SFR_RDATA,
    // Power control.
    input wire logic I_POWER_WRITE,
    input wire logic [7:0] I_POWER_WDATA,
    // Engine side.
    input wire logic O_START,
    input wire logic [1:0] O_FUNCTION,
    input wire logic O_ROTATE,
    input wire logic [1:0] O_PRESCALE,
    input wire logic [15:0] O_INIT_X,
    input wire logic O_DISABLE_REQUEST,
    input wire logic O_IRQ
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_NRST);

    AST_START_PULSE: assert property (O_START |=> !O_START)
        else $error("start pulse too long");
    AST_CTRL_LOCK: assert property (O_START |=>
        ($stable(O_FUNCTION) && $stable(O_ROTATE) && $stable(O_PRESCALE)) [*3])
        else $error("control changed while busy");
    AST_SHADOW_HOLD: assert property ($changed(O_INIT_X) |->
        $past(I_SFR_WRITE, 2) &&
        ($past(I_SFR_ADDR, 2) == rcp_pkg::ADDR_X_LOW ||
        $past(I_SFR_ADDR, 2) == rcp_pkg::ADDR_X_HIGH))
        else $error("shadow changed without write");
    AST_LOW_BYTE: assert property (
        I_SFR_WRITE && I_SFR_ADDR == rcp_pkg::ADDR_X_LOW |-> ##2
        O_INIT_X[7:0] == $past(I_SFR_WDATA, 2) && $stable(O_INIT_X[15:8]))
        else $error("low byte write wrong");
    AST_FUNC_SOURCE: assert property ($changed(O_FUNCTION) |->
        $past(I_SFR_WRITE, 2) &&
        $past(I_SFR_ADDR, 2) == rcp_pkg::ADDR_CONTROL &&
        O_FUNCTION == $past(I_SFR_WDATA[2:1], 2))
        else $error("function changed without write");
    AST_PRESCALE_KEEP: assert property ($changed(O_PRESCALE) |->
        O_PRESCALE != rcp_pkg::PRESCALE_RESERVED)
        else $error("reserved prescaler taken");
    AST_DISABLE: assert property (I_POWER_WRITE |-> ##2
        O_DISABLE_REQUEST == $past(I_POWER_WDATA[6], 2))
        else $error("disable request wrong");
    AST_READ_IDLE: assert property (O_SFR_RDATA != 8'h00 |->
        $past(I_SFR_READ))
        else $error("read data without read");
    AST_IRQ_PULSE: assert property (O_IRQ |=> !O_IRQ)
        else $error("interrupt pulse too long");
endmodule : rcp_top_assertions

bind rcp_top rcp_top_assertions #(.CALC_CYCLES(CALC_CYCLES))
    rcp_top_assertions_i (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
    .I_SFR_WRITE(I_SFR_WRITE), .I_SFR_READ(I_SFR_READ),
    .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WDATA(I_SFR_WDATA),
    .O_SFR_RDATA(O_SFR_RDATA), .I_POWER_WRITE(I_POWER_WRITE),
    .I_POWER_WDATA(I_POWER_WDATA), .O_START(O_START),
    .O_FUNCTION(O_FUNCTION), .O_ROTATE(O_ROTATE), .O_PRESCALE(O_PRESCALE),
    .O_INIT_X(O_INIT_X), .O_DISABLE_REQUEST(O_DISABLE_REQUEST),
    .O_IRQ(O_IRQ));

//--- testbench/tb_rcp_top.sv
`timescale 1ns/100ps
// Self-checking bench for the rotator register interface.
module tb_rcp_top;
    localparam int CYC = 12;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp_rd;
    } rcp_row_type;
    localparam rcp_row_type ROWS [9] = '{
        '{rcp_pkg::ADDR_CONTROL, 8'h72, 8'h72},
        '{rcp_pkg::ADDR_STATUS, 8'h10, 8'h10},
        '{rcp_pkg::ADDR_X_LOW, 8'h12, 8'h12},
        '{rcp_pkg::ADDR_X_HIGH, 8'h34, 8'h34},
        '{rcp_pkg::ADDR_Y_LOW, 8'h56, 8'h56},
        '{rcp_pkg::ADDR_Y_HIGH, 8'h78, 8'h78},
        '{rcp_pkg::ADDR_Z_LOW, 8'h9A, 8'h9A},
        '{rcp_pkg::ADDR_Z_HIGH, 8'hBC, 8'hBC},
        '{8'h99, 8'h55, 8'h00}};
    logic clk = 1'h0;
    logic nrst, wr, rd, pwr_wr, ovf, start, rot, dis_req, irq;
    logic [7:0] addr, wdata, rdata, pwr_wdata, pwr_rdata;
    logic [1:0] func, presc;
    logic [15:0] init_x, init_y, init_z;
    logic [2:0] load_mask;
    rcp_pkg::rcp_result_type result;
    int errors, n_tests, n_irq;

    always #4 clk = ~clk;
    always @(posedge clk) if (irq === 1'h1) n_irq <= n_irq + 1;

    rcp_top #(.CALC_CYCLES(CYC)) rcp_top_i (.I_CLOCK(clk), .I_NRST(nrst),
        .I_SFR_WRITE(wr), .I_SFR_READ(rd), .I_SFR_ADDR(addr),
        .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .I_POWER_WRITE(pwr_wr),
        .I_POWER_WDATA(pwr_wdata), .O_POWER_RDATA(pwr_rdata),
        .I_RESULT(result), .O_START(start), .O_FUNCTION(func),
        .O_ROTATE(rot), .O_PRESCALE(presc), .O_INIT_X(init_x),
        .O_INIT_Y(init_y), .O_INIT_Z(init_z), .O_LOAD_MASK(load_mask),
        .O_DISABLE_REQUEST(dis_req), .O_IRQ(irq));
    rcp_engine_model rcp_engine_model_i (.i_clk(clk), .i_nrst(nrst),
        .i_start(start), .i_init_x(init_x), .i_init_y(init_y),
        .i_init_z(init_z), .i_load_mask(load_mask), .i_overflow(ovf),
        .o_result(result));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask : wr_reg
    // Read data is registered and valid in the cycle after the strobe.
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk8(rdata, exp);
    endtask : chk_reg
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        {nrst, wr, rd, pwr_wr, ovf, errors, n_tests, n_irq} = '0;
        {addr, wdata, pwr_wdata} = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        chk_reg(rcp_pkg::ADDR_CONTROL, 8'h62);
        chk_reg(rcp_pkg::ADDR_STATUS, 8'h00);
        foreach (ROWS[i]) begin
            wr_reg(ROWS[i].addr, ROWS[i].wdata);
            chk_reg(ROWS[i].addr, ROWS[i].exp_rd);
        end
        // Explicit start in the same write as the mode bits.
        wr_reg(rcp_pkg::ADDR_STATUS, 8'h08);
        wr_reg(rcp_pkg::ADDR_CONTROL, 8'h73);
        @(posedge clk);
        chk_reg(rcp_pkg::ADDR_STATUS, 8'h09);
        wr_reg(rcp_pkg::ADDR_CONTROL, 8'h05);
        repeat (CYC + 4) @(posedge clk);
        chk_reg(rcp_pkg::ADDR_CONTROL, 8'h72);
        chk8(n_irq[7:0], 8'h01);
        chk_reg(rcp_pkg::ADDR_STATUS, 8'h0C);
        chk_reg(rcp_pkg::ADDR_X_LOW, 8'h12);
        chk_reg(rcp_pkg::ADDR_Z_HIGH, 8'hBC);
        chk_reg(rcp_pkg::ADDR_Z_LOW, 8'h9A);
        chk_reg(rcp_pkg::ADDR_STATUS, 8'h08);
        // Auto start with X kept and an overflow reported.
        ovf <= 1'h1;
        wr_reg(rcp_pkg::ADDR_CONTROL, 8'h62);
        wr_reg(rcp_pkg::ADDR_STATUS, 8'h20);
        wr_reg(rcp_pkg::ADDR_X_LOW, 8'h00);
        repeat (CYC + 4) @(posedge clk);
        chk_reg(rcp_pkg::ADDR_STATUS, 8'h26);
        chk_reg(rcp_pkg::ADDR_STATUS, 8'h24);
        chk_reg(rcp_pkg::ADDR_X_LOW, 8'h12);
        chk_reg(rcp_pkg::ADDR_Y_LOW, 8'h56);
        wr_reg(rcp_pkg::ADDR_STATUS, 8'h30);
        chk_reg(rcp_pkg::ADDR_X_LOW, 8'h00);
        chk8(n_irq[7:0], 8'h01);
        wr_reg(rcp_pkg::ADDR_CONTROL, 8'hB2);
        wr_reg(rcp_pkg::ADDR_CONTROL, 8'hF2);
        @(posedge clk);
        #1;
        chk8({6'h00, presc}, 8'h02);
        chk_reg(rcp_pkg::ADDR_CONTROL, 8'hB2);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            pwr_wr <= 1'h1;
            pwr_wdata <= (i == 0) ? 8'hFF : 8'h00;
            @(posedge clk);
            pwr_wr <= 1'h0;
            @(posedge clk);
            #1;
            chk8(pwr_rdata, (i == 0) ? 8'h7F : 8'h00);
            chk8({7'h00, dis_req}, (i == 0) ? 8'h01 : 8'h00);
        end
        // Reset in the middle of a calculation.
        wr_reg(rcp_pkg::ADDR_CONTROL, 8'h73);
        repeat (3) @(posedge clk);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        chk_reg(rcp_pkg::ADDR_STATUS, 8'h00);
        chk_reg(rcp_pkg::ADDR_CONTROL, 8'h62);
        complete_run();
    end
endmodule : tb_rcp_top
